// ==== hdl/vpa_emul_phy.sv ====
// Emulated PHY register bank with deterministic negotiation sequencer.
//
// Overview of operation
// - Negotiate only while enable bit 12 set.
// - Resets, reset bits and reload restart negotiation.
// - Writing one to bit 9 reruns negotiation.
// - First step sets negotiation complete status bit.
// - Second step sets page received expansion bit.
// - Third step latches resolved speed and duplex.
// - AND abilities, pick 100FD, 100HD, 10FD, 10HD.
// - Advertisement resets all four, software rewritable.
// - Advertisement edits wait for next negotiation.
// - Partner abilities come from duplex and straps.
// - No next page, remote fault or T4.
// - Strap changes never restart negotiation.
// - Common ability: partner able set, abilities loaded.
// - No common ability: parallel detect, half duplex.
// - Parallel detect speed follows speed strap.
// - Parallel detect shows exactly one ability bit.
// - Management side is local, fabric is partner.
// - Clause 22 bank reports speed, duplex, status.
// - Disabled negotiation forces speed and duplex bits.
// - Reset control bit 3 clears after 102 us.
// - Control bit 15 clears when reset completes.
`timescale 1ns/1ps
module vpa_emul_phy
  import vpa_pkg::*;
#(
  parameter int SWRST_CYCLES = VPA_SWRST_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  input wire logic adv_wr,
  input wire logic [15:0] adv_wdata,
  input wire logic rstctl_wr,
  input wire logic [15:0] rstctl_wdata,
  input wire logic reload_cmd,
  input wire logic mii_duplex_pin,
  input wire logic duplex_pol_strap,
  input wire logic speed_strap,
  output logic [15:0] emul_basic_control,
  output logic [15:0] emul_basic_status,
  output logic [15:0] emul_neg_expansion,
  output logic [15:0] emul_neg_advertise,
  output logic [15:0] emul_partner_ability,
  output logic [15:0] chip_reset_control,
  output logic op_speed_100,
  output logic op_full_duplex,
  output logic neg_busy
);

  // ********************************************************************
  // Helper functions
  // ********************************************************************
  function automatic vpa_result_type highest_common_choice(
    input logic [3:0] common
  );
    vpa_result_type r;
    r = '0;
    if ((common & VPA_TECH_100_FD) != 4'h0) begin
      r = '{speed_100: 1'b1, full_duplex: 1'b1};
    end else if ((common & VPA_TECH_100_HD) != 4'h0) begin
      r = '{speed_100: 1'b1, full_duplex: 1'b0};
    end else if ((common & VPA_TECH_10_FD) != 4'h0) begin
      r = '{speed_100: 1'b0, full_duplex: 1'b1};
    end else begin
      r = '{speed_100: 1'b0, full_duplex: 1'b0};
    end
    return r;
  endfunction

  // The emulated fabric partner offers every mode at or below its strap
  // speed; full duplex is offered when the duplex pin matches its polarity.
  function automatic logic [3:0] partner_tech(input vpa_straps_type s);
    logic full;
    logic [3:0] t;
    full = (s.mii_duplex == s.duplex_pol);
    t = VPA_TECH_10_HD;
    if (full) begin
      t = t | VPA_TECH_10_FD;
    end
    if (s.speed_100) begin
      t = t | VPA_TECH_100_HD;
      if (full) begin
        t = t | VPA_TECH_100_FD;
      end
    end
    return t;
  endfunction

  // ********************************************************************
  // Pin inputs and reset timer
  // ********************************************************************
  logic [2:0] strap_bits;
  vpa_straps_type straps;
  logic swrst_start;
  logic swrst_busy;
  logic swrst_done;

  vpa_sync3 #(
    .WIDTH(3)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in({mii_duplex_pin, duplex_pol_strap, speed_strap}),
    .stable_out(strap_bits)
  );

  assign straps = vpa_straps_type'(strap_bits);

  // ********************************************************************
  // Strap settling after reset
  // ********************************************************************
  // The synchroniser holds zeros through reset, so the run that reset
  // queues waits until its output has filled from the pins. This costs
  // four idle cycles but keeps the first result true to the straps.
  logic [3:0] settle_reg;
  logic [3:0] settle_next;
  logic settled;

  always_comb begin
    settle_next = {settle_reg[2:0], 1'b1};
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_reg <= 4'h0;
    end else begin
      settle_reg <= settle_next;
    end
  end

  assign settled = settle_reg[3];

  vpa_reset_timer #(
    .CW(VPA_TIMER_W),
    .CYCLES(SWRST_CYCLES)
  ) u_timer (
    .clock(clock),
    .resetn(resetn),
    .start(swrst_start),
    .busy(swrst_busy),
    .done(swrst_done)
  );

  // ********************************************************************
  // Register bank and negotiation sequencer
  // ********************************************************************
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] stat_reg;
  logic [15:0] stat_next;
  logic [15:0] exp_reg;
  logic [15:0] exp_next;
  logic [15:0] adv_reg;
  logic [15:0] adv_next;
  logic [15:0] lp_reg;
  logic [15:0] lp_next;
  vpa_result_type res_reg;
  vpa_result_type res_next;
  vpa_neg_state_type state_reg;
  vpa_neg_state_type state_next;
  logic pending_reg;
  logic pending_next;
  logic soft_clear;
  logic restart_req;
  logic neg_start;
  logic [3:0] common;

  always_comb begin
    ctrl_next = ctrl_reg;
    stat_next = stat_reg;
    exp_next = exp_reg;
    adv_next = adv_reg;
    lp_next = lp_reg;
    res_next = res_reg;
    state_next = state_reg;
    swrst_start = 1'b0;
    restart_req = 1'b0;
    neg_start = 1'b0;
    // The advertisement is sampled only at resolve time.
    common = adv_reg[VPA_TECH_LSB +: VPA_TECH_W] & partner_tech(straps);
    // Digital reset and reload act at once; the emulated PHY reset
    // reloads the bank only when its timed period ends.
    soft_clear = swrst_done || reload_cmd;
    if (rstctl_wr && rstctl_wdata[VPA_RSTCTL_DIGITAL_RST_BIT]) begin
      soft_clear = 1'b1;
    end
    if (rstctl_wr && rstctl_wdata[VPA_RSTCTL_EMUL_RST_BIT]) begin
      swrst_start = 1'b1;
    end
    if (ctrl_wr) begin
      ctrl_next = (ctrl_wdata & VPA_CTRL_WMASK) |
                  (ctrl_reg & ~VPA_CTRL_WMASK);
      if (ctrl_wdata[VPA_CTRL_RESET_BIT]) begin
        swrst_start = 1'b1;
        ctrl_next[VPA_CTRL_RESET_BIT] = 1'b1;
      end
      if (ctrl_wdata[VPA_CTRL_RESTART_BIT]) begin
        restart_req = 1'b1;
      end
    end
    if (adv_wr) begin
      // Next page, remote fault and T4 bits are not writable.
      adv_next = (adv_wdata & VPA_ADV_WMASK) | VPA_ADV_SELECTOR;
    end
    unique case (state_reg)
      VPA_NEG_IDLE: begin
        // Negotiation waits while an emulated PHY reset is still timing.
        if (pending_reg && ctrl_reg[VPA_CTRL_NEG_EN_BIT] && !swrst_busy &&
            settled) begin
          neg_start = 1'b1;
          stat_next[VPA_STAT_NEG_DONE_BIT] = 1'b0;
          exp_next[VPA_EXP_PAGE_RX_BIT] = 1'b0;
          state_next = VPA_NEG_COMPLETE;
        end
      end
      VPA_NEG_COMPLETE: begin
        stat_next[VPA_STAT_NEG_DONE_BIT] = 1'b1;
        state_next = VPA_NEG_PAGE;
      end
      VPA_NEG_PAGE: begin
        exp_next[VPA_EXP_PAGE_RX_BIT] = 1'b1;
        state_next = VPA_NEG_RESOLVE;
      end
      VPA_NEG_RESOLVE: begin
        // Advertisement is the management side, partner is the fabric.
        lp_next = VPA_ADV_SELECTOR;
        lp_next[VPA_PAUSE_LSB +: VPA_PAUSE_W] =
          adv_reg[VPA_PAUSE_LSB +: VPA_PAUSE_W];
        if (common != 4'h0) begin
          exp_next[VPA_EXP_PARTNER_ABLE_BIT] = 1'b1;
          lp_next[VPA_TECH_LSB +: VPA_TECH_W] = partner_tech(straps);
          res_next = highest_common_choice(common);
        end else begin
          exp_next[VPA_EXP_PARTNER_ABLE_BIT] = 1'b0;
          res_next.full_duplex = 1'b0;
          res_next.speed_100 = straps.speed_100;
          lp_next[VPA_TECH_LSB +: VPA_TECH_W] =
            straps.speed_100 ? VPA_TECH_100_HD : VPA_TECH_10_HD;
        end
        ctrl_next[VPA_CTRL_RESTART_BIT] = 1'b0;
        state_next = VPA_NEG_IDLE;
      end
    endcase
    if (!ctrl_reg[VPA_CTRL_NEG_EN_BIT]) begin
      res_next.speed_100 = ctrl_reg[VPA_CTRL_SPEED_BIT];
      res_next.full_duplex = ctrl_reg[VPA_CTRL_DUPLEX_BIT];
    end
    if (swrst_done) begin
      ctrl_next[VPA_CTRL_RESET_BIT] = 1'b0;
    end
    if (soft_clear) begin
      ctrl_next = VPA_CTRL_RESET;
      stat_next = VPA_STAT_RESET;
      exp_next = VPA_EXP_RESET;
      adv_next = VPA_ADV_RESET;
      lp_next = VPA_LP_RESET;
      state_next = VPA_NEG_IDLE;
      if (swrst_busy && !swrst_done) begin
        ctrl_next[VPA_CTRL_RESET_BIT] = 1'b1;
      end
    end
    // Any trigger leaves the restart bit set until the resolve step;
    // a trigger in the cycle of the clear wins over it.
    if (restart_req || soft_clear) begin
      ctrl_next[VPA_CTRL_RESTART_BIT] = 1'b1;
    end
    // Straps feed only the resolve step, so their edges start nothing.
    pending_next = restart_req || soft_clear ||
                   (pending_reg && !neg_start);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= VPA_CTRL_RESET;
      stat_reg <= VPA_STAT_RESET;
      exp_reg <= VPA_EXP_RESET;
      adv_reg <= VPA_ADV_RESET;
      lp_reg <= VPA_LP_RESET;
      res_reg <= '{speed_100: 1'b1, full_duplex: 1'b1};
      state_reg <= VPA_NEG_IDLE;
      pending_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      exp_reg <= exp_next;
      adv_reg <= adv_next;
      lp_reg <= lp_next;
      res_reg <= res_next;
      state_reg <= state_next;
      pending_reg <= pending_next;
    end
  end

  // ********************************************************************
  // Read-back and result outputs
  // ********************************************************************
  // Loopback, isolate and collision test are stored and read back only;
  // the emulated PHY carries no data path for them to act on.
  assign emul_basic_control = ctrl_reg;
  assign emul_basic_status = stat_reg;
  assign emul_neg_expansion = exp_reg;
  assign emul_neg_advertise = adv_reg;
  assign emul_partner_ability = lp_reg;
  assign chip_reset_control = {12'h000, swrst_busy, 3'h0};
  assign op_speed_100 = res_reg.speed_100;
  assign op_full_duplex = res_reg.full_duplex;
  assign neg_busy = (state_reg != VPA_NEG_IDLE);

endmodule // vpa_emul_phy

// ==== hdl/vpa_pkg.sv ====
// Package with constants and types of the emulated PHY negotiation block.
package vpa_pkg;

  // ********************************************************************
  // Register widths and field positions
  // ********************************************************************
  localparam int VPA_REG_W = 16;
  localparam int VPA_TECH_W = 4;
  localparam int VPA_PAUSE_W = 2;

  localparam int VPA_CTRL_RESET_BIT = 15;
  localparam int VPA_CTRL_LOOPBACK_BIT = 14;
  localparam int VPA_CTRL_SPEED_BIT = 13;
  localparam int VPA_CTRL_NEG_EN_BIT = 12;
  localparam int VPA_CTRL_ISOLATE_BIT = 10;
  localparam int VPA_CTRL_RESTART_BIT = 9;
  localparam int VPA_CTRL_DUPLEX_BIT = 8;
  localparam int VPA_CTRL_COLTEST_BIT = 7;

  localparam int VPA_STAT_NEG_DONE_BIT = 5;
  localparam int VPA_EXP_PAGE_RX_BIT = 1;
  localparam int VPA_EXP_PARTNER_ABLE_BIT = 0;

  localparam int VPA_TECH_LSB = 5;
  localparam int VPA_PAUSE_LSB = 10;

  localparam int VPA_RSTCTL_EMUL_RST_BIT = 3;
  localparam int VPA_RSTCTL_DIGITAL_RST_BIT = 10;

  // Technology field bit order: 100 full, 100 half, 10 full, 10 half.
  localparam logic [3:0] VPA_TECH_ALL = 4'hF;
  localparam logic [3:0] VPA_TECH_100_FD = 4'h8;
  localparam logic [3:0] VPA_TECH_100_HD = 4'h4;
  localparam logic [3:0] VPA_TECH_10_FD = 4'h2;
  localparam logic [3:0] VPA_TECH_10_HD = 4'h1;

  // ********************************************************************
  // Reset values and write masks
  // ********************************************************************
  // Negotiation enabled, 100 Mbps, full duplex, restart pending.
  localparam logic [15:0] VPA_CTRL_RESET = 16'h3300;
  localparam logic [15:0] VPA_CTRL_WMASK = 16'h7580;
  // Abilities 100FD/100HD/10FD/10HD, negotiation able, link up, extended.
  localparam logic [15:0] VPA_STAT_RESET = 16'h780D;
  localparam logic [15:0] VPA_EXP_RESET = 16'h0000;
  localparam logic [15:0] VPA_ADV_SELECTOR = 16'h0001;
  localparam logic [15:0] VPA_ADV_RESET = 16'h01E1;
  localparam logic [15:0] VPA_ADV_WMASK = 16'h0DE0;
  localparam logic [15:0] VPA_LP_RESET = 16'h0000;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int VPA_CLK_PERIOD_NS = 10;
  localparam int VPA_SWRST_TIME_NS = 102000;
  localparam int VPA_SWRST_CYCLES = VPA_SWRST_TIME_NS / VPA_CLK_PERIOD_NS;
  localparam int VPA_TIMER_W = 16;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic mii_duplex;
    logic duplex_pol;
    logic speed_100;
  } vpa_straps_type;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } vpa_result_type;

  typedef enum logic [1:0] {
    VPA_NEG_IDLE,
    VPA_NEG_COMPLETE,
    VPA_NEG_PAGE,
    VPA_NEG_RESOLVE
  } vpa_neg_state_type;

endpackage

// ==== hdl/vpa_sync3.sv ====
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module vpa_sync3 #(
  parameter int WIDTH = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] stable_out
);
  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      stable_next[i] = (ff2_reg[i] == ff3_reg[i]) ? ff3_reg[i] : stable_reg[i];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      stable_reg <= '0;
    end else begin
      ff1_reg <= pin_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable_out = stable_reg;
endmodule // vpa_sync3

// ==== hdl/vpa_reset_timer.sv ====
// Down counter that times the emulated PHY software reset.
`timescale 1ns/1ps
module vpa_reset_timer #(
  parameter int CW = 16,
  parameter int CYCLES = 10200
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  // A new start while running reloads the full period.
  always_comb begin
    count_next = count_reg;
    if (start) begin
      count_next = CW'(CYCLES);
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != '0);
  assign done = (count_reg == CW'(1)) && !start;
endmodule // vpa_reset_timer

// ==== verification/vpa_emul_phy_sva.sv ====
// Concurrent checks on the ports of the emulated PHY negotiation block.
`timescale 1ns/1ps
module vpa_emul_phy_sva #(
  parameter int SWRST_CYCLES = 10200
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [15:0] emul_basic_control,
  input wire logic [15:0] emul_basic_status,
  input wire logic [15:0] emul_neg_expansion,
  input wire logic [15:0] emul_neg_advertise,
  input wire logic [15:0] emul_partner_ability,
  input wire logic [15:0] chip_reset_control,
  input wire logic op_speed_100,
  input wire logic op_full_duplex,
  input wire logic neg_busy
);
  logic [3:0] cm;
  int hi_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  assign cm = emul_neg_advertise[8:5] & emul_partner_ability[8:5];
  // The timer length is counted here because it is far too long to unroll.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) hi_cnt <= 0;
    else hi_cnt <= chip_reset_control[3] ? hi_cnt + 1 : 0;
  end
  property p_steps;
    $rose(neg_busy) |-> !emul_basic_status[5] && !emul_neg_expansion[1]
      ##1 emul_basic_status[5] ##1 emul_neg_expansion[1]
      ##1 !neg_busy && !emul_basic_control[9];
  endproperty
  a_steps: assert property (p_steps) else $error("bad step order");
  property p_pend;
    neg_busy |-> emul_basic_control[9];
  endproperty
  a_pend: assert property (p_pend) else $error("restart bit low");
  property p_hcd;
    $fell(neg_busy) && cm != 4'h0 |-> emul_neg_expansion[0] &&
      op_speed_100 == (cm[3] | cm[2]) &&
      op_full_duplex == (cm[3] | (!cm[2] & cm[1]));
  endproperty
  a_hcd: assert property (p_hcd) else $error("bad common choice");
  property p_pardet;
    $fell(neg_busy) && cm == 4'h0 |-> !emul_neg_expansion[0] &&
      !op_full_duplex && $onehot(emul_partner_ability[8:5]);
  endproperty
  a_pardet: assert property (p_pardet) else $error("bad fallback");
  property p_forced;
    !emul_basic_control[12] && !$past(emul_basic_control[12]) |->
      op_speed_100 == $past(emul_basic_control[13]) &&
      op_full_duplex == $past(emul_basic_control[8]);
  endproperty
  a_forced: assert property (p_forced) else $error("bad forced mode");
  property p_no_np;
    {emul_neg_advertise[15], emul_neg_advertise[13], emul_neg_advertise[9],
     emul_partner_ability[15], emul_partner_ability[13],
     emul_partner_ability[9]} == 6'h00;
  endproperty
  a_no_np: assert property (p_no_np) else $error("extra ability");
  property p_en;
    $rose(neg_busy) |-> $past(emul_basic_control[12]);
  endproperty
  a_en: assert property (p_en) else $error("ran while disabled");
  property p_adv_hold;
    $changed(emul_neg_advertise) && !emul_basic_control[9] &&
      $stable(emul_basic_control) |=> $stable(op_speed_100) &&
      $stable(op_full_duplex);
  endproperty
  a_adv_hold: assert property (p_adv_hold) else $error("early result");
  property p_rst_len;
    hi_cnt <= SWRST_CYCLES + 2 &&
      (!$fell(chip_reset_control[3]) || hi_cnt >= SWRST_CYCLES - 2);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("bad reset time");
  property p_ctrl15;
    emul_basic_control[15] |-> chip_reset_control[3];
  endproperty
  a_ctrl15: assert property (p_ctrl15) else $error("bit 15 stuck");
endmodule // vpa_emul_phy_sva
bind vpa_emul_phy vpa_emul_phy_sva #(.SWRST_CYCLES(SWRST_CYCLES)) u_sva (
  .clock(clock), .resetn(resetn), .emul_basic_control(emul_basic_control),
  .emul_basic_status(emul_basic_status),
  .emul_neg_expansion(emul_neg_expansion),
  .emul_neg_advertise(emul_neg_advertise),
  .emul_partner_ability(emul_partner_ability),
  .chip_reset_control(chip_reset_control), .op_speed_100(op_speed_100),
  .op_full_duplex(op_full_duplex), .neg_busy(neg_busy));

// ==== verification/vpa_host_model.sv ====
// Management host model that issues register writes by strobe.
`timescale 1ns/1ps
module vpa_host_model (
  input wire logic clock,
  output logic ctrl_wr,
  output logic adv_wr,
  output logic rstctl_wr,
  output logic reload_cmd,
  output logic [15:0] wdata
);
  initial begin
    {ctrl_wr, adv_wr, rstctl_wr, reload_cmd} = 4'h0;
    wdata = 16'h0000;
  end
  // Kind 0 control, 1 advertise, 2 reset control, 3 reload.
  task automatic wr(input int k, input logic [15:0] d);
    @(posedge clock);
    #2;
    ctrl_wr = k == 0;
    adv_wr = k == 1;
    rstctl_wr = k == 2;
    reload_cmd = k == 3;
    wdata = d;
    @(posedge clock);
    #2;
    {ctrl_wr, adv_wr, rstctl_wr, reload_cmd} = 4'h0;
    // Stale data is inverted so nothing can lean on a held value.
    wdata = ~d;
  endtask
endmodule // vpa_host_model

// ==== verification/test_vpa_emul_phy.sv ====
// Self-checking bench for the emulated PHY negotiation block.
`timescale 1ns/1ps
module test_vpa_emul_phy;
  import vpa_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic c_wr, a_wr, r_wr, rld, sp, fd, busy;
  logic [15:0] wd, ctl, sta, exq, adv, lpa, rsc, d;
  logic [3:0] a;
  vpa_straps_type pins = '0;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int m_sp, m_fd, m_ex, m_lp;
  vpa_host_model HOST (.clock(clock), .ctrl_wr(c_wr), .adv_wr(a_wr),
    .rstctl_wr(r_wr), .reload_cmd(rld), .wdata(wd));
  vpa_emul_phy #(.SWRST_CYCLES(20)) DUT (.clock(clock), .resetn(resetn),
    .ctrl_wr(c_wr), .ctrl_wdata(wd), .adv_wr(a_wr), .adv_wdata(wd),
    .rstctl_wr(r_wr), .rstctl_wdata(wd), .reload_cmd(rld),
    .mii_duplex_pin(pins.mii_duplex), .duplex_pol_strap(pins.duplex_pol),
    .speed_strap(pins.speed_100), .emul_basic_control(ctl),
    .emul_basic_status(sta), .emul_neg_expansion(exq),
    .emul_neg_advertise(adv), .emul_partner_ability(lpa),
    .chip_reset_control(rsc), .op_speed_100(sp), .op_full_duplex(fd),
    .neg_busy(busy));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic chk_res(input logic [3:0] t);
    int full, p, c;
    full = pins.mii_duplex == pins.duplex_pol;
    p = 1 + 2 * full + 4 * pins.speed_100 + 8 * (pins.speed_100 & full);
    c = t & p;
    m_ex = c != 0;
    m_sp = c != 0 ? c >= 4 : pins.speed_100;
    m_fd = c != 0 ? (c >= 8 || c == 2 || c == 3) : 0;
    m_lp = c != 0 ? p : (pins.speed_100 ? 4 : 1);
    chk(16'(sp), 16'(m_sp));
    chk(16'(fd), 16'(m_fd));
    chk(16'(exq[0]), 16'(m_ex));
    chk(16'(lpa[8:5]), 16'(m_lp));
    chk(16'({sta[5], exq[1]}), 16'h3);
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 80 && busy !== 1'b1; k++) @(posedge clock) #2;
    for (k = 0; k < 10 && busy !== 1'b0; k++) @(posedge clock) #2;
    chk(16'(busy), 16'h0);
  endtask
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hB87D45F3));
    repeat (8) @(posedge clock);
    chk(ctl, VPA_CTRL_RESET);
    chk(sta, VPA_STAT_RESET);
    chk(exq, VPA_EXP_RESET);
    chk(adv, VPA_ADV_RESET);
    chk(lpa, VPA_LP_RESET);
    chk(rsc, 16'h0000);
    #2 resetn = 1'b1;
    wait_done();
    chk_res(4'hF);
    for (int i = 0; i < 24; i++) begin
      pins = vpa_straps_type'(i[2:0]);
      repeat (6) @(posedge clock) #2;
      chk(16'(busy), 16'h0);
      chk({15'h0, sp}, 16'(m_sp));
      d = 16'($urandom);
      if (i == 5) d[8:5] = 4'h0;
      a = d[8:5];
      HOST.wr(1, d);
      repeat (3) @(posedge clock) #2;
      chk(adv, (d & VPA_ADV_WMASK) | VPA_ADV_SELECTOR);
      chk({15'h0, fd}, 16'(m_fd));
      HOST.wr(0, 16'h1200);
      wait_done();
      chk_res(a);
    end
    for (int i = 0; i < 4; i++) begin
      HOST.wr(0, {2'b00, i[1], 4'h0, i[0], 8'h00});
      repeat (3) @(posedge clock) #2;
      chk(16'({sp, fd}), 16'(i[1:0]));
    end
    HOST.wr(0, 16'h0200);
    repeat (5) @(posedge clock) #2;
    chk(16'({busy, ctl[9]}), 16'h1);
    HOST.wr(0, 16'h1000);
    wait_done();
    chk_res(a);
    for (int k = 0; k < 4; k++) begin
      HOST.wr(1, 16'h0000);
      case (k)
        0: HOST.wr(2, 16'h0008);
        1: HOST.wr(0, 16'h9000);
        2: HOST.wr(2, 16'h0400);
        default: HOST.wr(3, 16'h0000);
      endcase
      #2 chk(16'(k == 1 ? ctl[15] : k == 0 ? rsc[3] : ctl[9]), 16'h1);
      wait_done();
      chk(adv, VPA_ADV_RESET);
      chk(16'({rsc[3], ctl[15]}), 16'h0);
      chk_res(4'hF);
    end
    // A hardware reset with the straps held high must resolve from them.
    @(posedge clock) #2 resetn = 1'b0;
    repeat (2) @(posedge clock);
    chk(ctl, VPA_CTRL_RESET);
    #2 resetn = 1'b1;
    wait_done();
    chk_res(4'hF);
    report_and_stop();
  end
endmodule // test_vpa_emul_phy
